// ==== efs_pkg.sv ====
// shared constants and types for the frame-streaming serial link
package efs_pkg;
	// command word layout
	localparam int            CMD_W       = 32;
	localparam int            CMD_WR_BIT  = 31;
	localparam int            ADDR_HI     = 30;
	localparam int            ADDR_LO     = 24;
	localparam int            DATA_W      = 24;
	// register addresses
	localparam logic [6:0]    A_CHAN_CTL  = 7'h01;
	localparam logic [6:0]    A_PACE_CTL  = 7'h04;
	localparam logic [6:0]    A_CMREF_CTL = 7'h05;
	localparam logic [6:0]    A_PACE_THR  = 7'h07;
	localparam logic [6:0]    A_TEST_CTL  = 7'h08;
	localparam logic [6:0]    A_FRAME_CTL = 7'h0a;
	localparam logic [6:0]    A_FILT_CTL  = 7'h0b;
	localparam logic [6:0]    A_PACE_MEAS = 7'h1a;
	localparam logic [6:0]    A_FRAME_HDR = 7'h40;
	localparam logic [6:0]    A_CHAN_WORD = 7'h11;
	localparam logic [6:0]    A_RESP_WORD = 7'h1b;
	localparam logic [6:0]    A_LOFF_WORD = 7'h1c;
	// reset values
	localparam logic [23:0]   PACE_THR_RST = 24'h242424;
	localparam logic [23:0]   FRAME_HDR_RST = 24'h800000;
	localparam logic [23:0]   CTL_RST      = 24'h000000;
	// channel control fields
	localparam int            CH_CONV_BIT  = 3;
	localparam int            CH_GANG_BIT  = 4;
	localparam int            CH_MASTER_BIT = 5;
	localparam int            CH_EXTCLK_BIT = 6;
	// frame control fields
	localparam int            FRM_ELEC_BIT = 4;
	localparam int            FRM_NOLOFF_BIT = 11;
	localparam int            FRM_NORESP_BIT = 13;
	localparam int            FRM_NOPACE_BIT = 14;
	// common-mode reference fields
	localparam int            CM_EXT_IN_BIT = 2;
	localparam int            CM_DRIVE_BIT = 3;
	// pace control fields
	localparam int            PACE_EN_LO   = 0;
	localparam int            PACE_WFILT_BIT = 10;
	localparam int            PACE_VFILT_BIT = 11;
	localparam int            HDR_PACE_LO  = 20;
	// word slots within a frame
	localparam logic [2:0]    WI_HDR  = 3'h0;
	localparam logic [2:0]    WI_PACE = 3'h4;
	localparam logic [2:0]    WI_RESP = 3'h5;
	localparam logic [2:0]    WI_LOFF = 3'h6;
	localparam logic [2:0]    WI_WRAP = 3'h7;
	// timing
	localparam int            CLK_HZ        = 10_000_000;
	localparam int            CLK_PERIOD_NS = 100;
	localparam int            FRAME_RATE_HZ = 2000;
	localparam int            FRAME_CYC_DFLT = CLK_HZ / FRAME_RATE_HZ;
	localparam int            SCLK_PERIOD_NS = 800;
	localparam int            SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int            CS_GAP_CYC    = 4;
	typedef enum logic [1:0] {CV_IDLE, CV_WAIT_SYNC, CV_RUN} efs_conv_t;
	typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_GAP} efs_hstate_t;
endpackage : efs_pkg

// ==== efs_link_if.sv ====
// serial link between host controller and front end
`timescale 1ns/1ns
interface efs_link_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic sdo;
	modport dev (input sclk, input cs_n, input sdi, output sdo);
	modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface : efs_link_if

// ==== efs_device.sv ====
// front-end end of the link: command decode, registers, frame stream, ganging
//
// How it works
// [R01] 32-bit command: write bit, address, data, msb first
// [R02] pace control enables instances and filters
// [R03] frame header read starts frame streaming
// [R04] host keeps clocking to read frame_header_stream
// [R05] valid pace sets header flags, loads measurement
// [R06] pace threshold resets to 0x242424
// [R07] pace word sent only if frame control allows
// [R08] frame control sets words, format, always send
// [R09] common-mode reference selects external input
// [R10] gang slave waits for master sync edge
// [R11] host configures slave before starting conversion
// [R12] frame length configurable per device
// [R13] master drives common mode out to slave
// [R14] gang master emits sync edge on start
// [R15] host issues frame read to both devices
// [R16] host computes leads from electrode words; efs_host passes the received words out on rsp_word unchanged
// [R17] command during stream halts conversion
// [R18] test tone needs electrode format
`timescale 1ns/1ns
module efs_device
	import efs_pkg::*;
#(
	parameter int FRAME_CYCLES = FRAME_CYC_DFLT
)(
	input  wire logic         clock,          // system clock
	input  wire logic         rst,            // synchronous reset
	efs_link_if.dev           link,           // serial link
	input  wire logic [71:0]  chan_samples,   // three 24-bit channel samples
	input  wire logic [23:0]  resp_magnitude, // respiration magnitude
	input  wire logic [23:0]  leadoff_status, // lead-off status word
	input  wire logic         pace_event,     // pace candidate pulse
	input  wire logic [2:0]   pace_lead_hits, // leads that saw the pulse
	input  wire logic [23:0]  pace_meas_in,   // width [7:0], height [15:8]
	input  wire logic         gang_sync_in,   // sync from gang master
	output logic              gang_sync_out,  // sync to gang slave
	output logic              cm_drive_out,   // drive common mode out
	output logic              cm_ext_select,  // take common mode from input
	output logic              clk_ext_select, // clock from master input
	output logic              converting,     // conversion running
	output logic [23:0]       pace_threshold, // pace amplitude threshold
	output logic [23:0]       test_tone_cfg,  // test signal setup
	output logic [23:0]       filter_cfg      // filter setup
);
	typedef struct packed {
		logic [1:0]  sclk_s;
		logic [1:0]  cs_s;
		logic [1:0]  sdi_s;
		logic [1:0]  gin_s;
		logic        sclk_prev;
		logic        gin_prev;
		logic [5:0]  bitcnt;
		logic [31:0] in_sr;
		logic [31:0] out_sr;
		logic [31:0] rsp;
		logic        load_pend;
		logic [23:0] chan;
		logic [23:0] pace;
		logic [23:0] cmref;
		logic [23:0] thr;
		logic [23:0] test;
		logic [23:0] frm;
		logic [23:0] filt;
		logic [23:0] hdr;
		logic [23:0] pmeas;
		logic        stream;
		logic [2:0]  widx;
		efs_conv_t   conv;
		logic [15:0] tmr;
		logic [71:0] snap;
		logic        gang_out;
	} efs_dev_st_t;

	efs_dev_st_t q;
	efs_dev_st_t d;

	////////////////////////////////////////////////////////////////////////////
	// frame word builder: electrode words raw, vector words as differences
	function automatic logic [31:0] frame_word(input logic [2:0] i, input efs_dev_st_t s);
		logic [23:0] a;
		logic [23:0] b;
		a = 24'h000000;
		b = 24'h000000;
		frame_word = 32'h00000000;
		if (i == WI_HDR)
			frame_word = {1'b0, A_FRAME_HDR, s.hdr};
		else if (i < WI_PACE)
		begin
			a = s.snap[(i - 3'h1) * 24 +: 24];
			b = s.snap[((i == 3'h3) ? 0 : i * 24) +: 24];
			if (s.frm[FRM_ELEC_BIT])                      // R08 R18
				frame_word = {1'b0, A_CHAN_WORD + 7'(i - 3'h1), a};
			else
				frame_word = {1'b0, A_CHAN_WORD + 7'(i - 3'h1), b - a};
		end
		else if (i == WI_PACE)
			frame_word = {1'b0, A_PACE_MEAS, s.pmeas};
		else if (i == WI_RESP)
			frame_word = {1'b0, A_RESP_WORD, resp_magnitude};
		else
			frame_word = {1'b0, A_LOFF_WORD, leadoff_status};
	endfunction : frame_word

	// next slot, skipping words that frame control leaves out
	function automatic logic [2:0] next_word(input logic [2:0] i, input logic [23:0] f);
		logic [2:0] n;
		n = i + 3'h1;
		if (n == WI_PACE && f[FRM_NOPACE_BIT])            // R07
			n = WI_RESP;
		if (n == WI_RESP && f[FRM_NORESP_BIT])            // R08 R12
			n = WI_LOFF;
		if (n == WI_LOFF && f[FRM_NOLOFF_BIT])
			n = WI_WRAP;
		if (n == WI_WRAP)
			n = WI_HDR;
		next_word = n;
	endfunction : next_word

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb
	begin
		logic        rise;
		logic        fall;
		logic        gin_rise;
		logic        cmd;
		logic        pvalid;
		logic [2:0]  hits;
		logic [2:0]  ni;
		logic [31:0] w;
		logic [6:0]  addr;
		logic [23:0] dat;
		logic [23:0] rv;
		d = q;
		rise = 1'b0;
		fall = 1'b0;
		gin_rise = 1'b0;
		cmd = 1'b0;
		pvalid = 1'b0;
		hits = 3'h0;
		ni = 3'h0;
		w = 32'h00000000;
		addr = 7'h00;
		dat = 24'h000000;
		rv = 24'h000000;
		// pin synchronisers; edges only from the second stage
		d.sclk_s = {q.sclk_s[0], link.sclk};
		d.cs_s = {q.cs_s[0], link.cs_n};
		d.sdi_s = {q.sdi_s[0], link.sdi};
		d.gin_s = {q.gin_s[0], gang_sync_in};
		d.sclk_prev = q.sclk_s[1];
		d.gin_prev = q.gin_s[1];
		rise = q.sclk_s[1] & ~q.sclk_prev;
		fall = ~q.sclk_s[1] & q.sclk_prev;
		gin_rise = q.gin_s[1] & ~q.gin_prev;

		// conversion sequencing and frame timer
		unique case (q.conv)
			CV_IDLE: d.tmr = 16'h0000;
			CV_WAIT_SYNC:
				if (gin_rise)                             // R10
					d.conv = CV_RUN;
			CV_RUN:
				if (q.tmr == 16'(FRAME_CYCLES - 1))
				begin
					d.tmr = 16'h0000;
					d.snap = chan_samples;
				end
				else
					d.tmr = q.tmr + 16'h0001;
		endcase

		// serial shift engine; sdo moves on falling edges, sdi taken on rising.
		// the last fall of a word comes with the select release, so a pending
		// answer is still loaded then and held over the gap
		if (fall && (q.load_pend || !q.cs_s[1]))
		begin
			d.out_sr = q.load_pend ? q.rsp : {q.out_sr[30:0], 1'b0};
			d.load_pend = 1'b0;
		end
		if (q.cs_s[1])
			d.bitcnt = 6'h00;
		else
		begin
			if (rise)
			begin
				d.in_sr = {q.in_sr[30:0], q.sdi_s[1]};
				d.bitcnt = q.bitcnt + 6'h01;
				if (q.bitcnt == 6'(CMD_W - 1))
				begin
					w = {q.in_sr[30:0], q.sdi_s[1]};      // R01
					addr = w[ADDR_HI:ADDR_LO];
					dat = w[DATA_W-1:0];
					d.bitcnt = 6'h00;
					d.load_pend = 1'b1;
					d.rsp = 32'h00000000;
					cmd = ~q.stream | (w != 32'h00000000);
					if (q.stream && w != 32'h00000000)
					begin
						d.stream = 1'b0;                  // R17
						d.conv = CV_IDLE;
						d.gang_out = 1'b0;
					end
					else if (q.stream)
					begin
						ni = next_word(q.widx, q.frm);    // R04
						d.widx = ni;
						d.rsp = frame_word(ni, q);
						if (ni == WI_HDR)
							d.hdr[HDR_PACE_LO +: 3] = 3'h0;
					end
					if (cmd && w[CMD_WR_BIT])
					begin
						unique case (addr)
							A_CHAN_CTL:
							begin
								d.chan = dat;
								d.tmr = 16'h0000;
								if (!dat[CH_CONV_BIT])
								begin
									d.conv = CV_IDLE;
									d.gang_out = 1'b0;
								end
								else if (dat[CH_GANG_BIT] && !dat[CH_MASTER_BIT])
									d.conv = CV_WAIT_SYNC;    // R10
								else
								begin
									d.conv = CV_RUN;
									d.gang_out = dat[CH_GANG_BIT]; // R14
								end
							end
							A_PACE_CTL:  d.pace = dat;        // R02
							A_CMREF_CTL: d.cmref = dat;       // R09 R13
							A_PACE_THR:  d.thr = dat;
							A_TEST_CTL:  d.test = dat;
							A_FRAME_CTL: d.frm = dat;         // R08 R12
							A_FILT_CTL:  d.filt = dat;
							default: ;
						endcase
					end
					else if (cmd)
					begin
						unique case (addr)
							A_CHAN_CTL:  rv = q.chan;
							A_PACE_CTL:  rv = q.pace;
							A_CMREF_CTL: rv = q.cmref;
							A_PACE_THR:  rv = q.thr;
							A_TEST_CTL:  rv = q.test;
							A_FRAME_CTL: rv = q.frm;
							A_FILT_CTL:  rv = q.filt;
							A_PACE_MEAS: rv = q.pmeas;
							default:     rv = 24'h000000;
						endcase
						d.rsp = {1'b0, addr, rv};
						if (addr == A_FRAME_HDR)
						begin
							d.stream = 1'b1;                  // R03
							d.widx = WI_HDR;
							d.rsp = frame_word(WI_HDR, q);
							d.hdr[HDR_PACE_LO +: 3] = 3'h0;
						end
					end
				end
			end
		end

		// pace capture; a new flag beats the clear made by sending the header
		hits = pace_lead_hits & q.pace[PACE_EN_LO +: 3];
		pvalid = (~q.pace[PACE_WFILT_BIT] | (pace_meas_in[7:0] != 8'h00))
		       & (~q.pace[PACE_VFILT_BIT] | (pace_meas_in[15:8] != 8'h00));
		if (q.conv == CV_RUN && pace_event && hits != 3'h0 && pvalid)
		begin
			d.pmeas = pace_meas_in;                       // R05
			d.hdr[HDR_PACE_LO +: 3] = d.hdr[HDR_PACE_LO +: 3] | hits;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			q <= '0;
			q.cs_s <= 2'h3;
			q.chan <= CTL_RST;
			q.thr <= PACE_THR_RST;                        // R06
			q.hdr <= FRAME_HDR_RST;
		end
		else
			q <= d;
	end

	// outputs straight from state bits
	assign link.sdo = q.out_sr[31];
	assign gang_sync_out = q.gang_out;                    // R14
	assign cm_drive_out = q.cmref[CM_DRIVE_BIT];          // R13
	assign cm_ext_select = q.cmref[CM_EXT_IN_BIT];        // R09
	assign clk_ext_select = q.chan[CH_EXTCLK_BIT];        // R10
	assign converting = (q.conv == CV_RUN);
	assign pace_threshold = q.thr;
	assign test_tone_cfg = q.test;
	assign filter_cfg = q.filt;
endmodule : efs_device

// ==== efs_host.sv ====
// host end of the link: command serializer and frame reader
`timescale 1ns/1ns
module efs_host
	import efs_pkg::*;
(
	input  wire logic         clock,       // system clock
	input  wire logic         rst,         // synchronous reset
	efs_link_if.host          link,        // serial link
	input  wire logic         cmd_valid,   // command offered
	input  wire logic [31:0]  cmd_word,    // command word
	output logic              cmd_ready,   // command taken this cycle if valid
	input  wire logic         stream_stop, // leave streaming at word end
	output logic              rsp_valid,   // one-cycle pulse per received word
	output logic [31:0]       rsp_word,    // received word
	output logic              streaming    // frame read in progress
);
	typedef struct packed {
		efs_hstate_t st;
		logic [1:0]  sdo_s;
		logic [3:0]  div;
		logic [5:0]  bitcnt;
		logic [31:0] tx;
		logic [31:0] rx;
		logic        sclk;
		logic        cs_n;
		logic        sdi;
		logic        ready;
		logic        rvalid;
		logic [31:0] rword;
		logic        stream;
	} efs_host_st_t;

	efs_host_st_t q;
	efs_host_st_t d;

	////////////////////////////////////////////////////////////////////////////
	// next-state logic; sclk made here by dividing the system clock
	always_comb
	begin
		logic frame_rd;
		logic word_end;
		d = q;
		frame_rd = ~cmd_word[CMD_WR_BIT] && cmd_word[ADDR_HI:ADDR_LO] == A_FRAME_HDR;
		word_end = 1'b0;
		d.sdo_s = {q.sdo_s[0], link.sdo};
		d.rvalid = 1'b0;
		d.ready = 1'b0;
		unique case (q.st)
			HS_IDLE:
			begin
				d.ready = 1'b1;
				if (cmd_valid && q.ready)
				begin
					d.st = HS_SHIFT;
					d.ready = 1'b0;
					d.cs_n = 1'b0;
					d.tx = cmd_word;                          // R01
					d.sdi = cmd_word[31];
					d.div = 4'h0;
					d.bitcnt = 6'h00;
					d.stream = frame_rd;                      // R15
				end
			end
			HS_SHIFT:
			begin
				d.div = q.div + 4'h1;
				if (q.div == 4'(SCLK_HALF_CYC - 1))
				begin
					d.div = 4'h0;
					d.sclk = ~q.sclk;
					if (q.sclk)
					begin
						// falling edge: take sdo, present next sdi bit
						d.rx = {q.rx[30:0], q.sdo_s[1]};
						d.tx = {q.tx[30:0], 1'b0};
						d.sdi = q.tx[30];
						d.bitcnt = q.bitcnt + 6'h01;
						word_end = (q.bitcnt == 6'(CMD_W - 1));
					end
				end
				// while streaming, ready is raised exactly for the cycle on which a word ends
				d.ready = q.stream && q.sclk && q.bitcnt == 6'(CMD_W - 1)
				       && q.div == 4'(SCLK_HALF_CYC - 2);
				if (word_end)
				begin
					d.bitcnt = 6'h00;
					d.rvalid = 1'b1;
					d.rword = {q.rx[30:0], q.sdo_s[1]};       // R16
					if (q.stream && cmd_valid && q.ready)
					begin
						d.tx = cmd_word;
						d.sdi = cmd_word[31];
						d.stream = frame_rd;
					end
					else if (q.stream && !stream_stop)
					begin
						d.tx = 32'h00000000;                  // R17
						d.sdi = 1'b0;                         // R04
					end
					else
					begin
						d.st = HS_GAP;
						d.cs_n = 1'b1;
						d.sdi = 1'b0;
						d.stream = 1'b0;
						d.div = 4'h0;
					end
				end
			end
			HS_GAP:
			begin
				// idle gap so back-to-back commands are framed by cs_n
				d.div = q.div + 4'h1;
				if (q.div == 4'(CS_GAP_CYC - 1))
				begin
					d.st = HS_IDLE;                           // R11
					d.div = 4'h0;
				end
			end
			default: d.st = HS_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			q <= '0;
			q.cs_n <= 1'b1;
		end
		else
			q <= d;
	end

	assign link.sclk = q.sclk;
	assign link.cs_n = q.cs_n;
	assign link.sdi = q.sdi;
	assign cmd_ready = q.ready;
	assign rsp_valid = q.rvalid;
	assign rsp_word = q.rword;
	assign streaming = q.stream;
endmodule : efs_host

// ==== efs_link_properties.sv ====
// timing and framing properties of the serial link between the two ends
`timescale 1ns/1ns
module efs_link_properties
	import efs_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic rst,   // synchronous reset
	input wire logic sclk,  // serial clock
	input wire logic cs_n,  // select, active low
	input wire logic sdi,   // host to device data
	input wire logic sdo    // device to host data
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////
	// sclk rises seen in the current word, modulo 32; cleared while deselected
	logic [4:0] rise_cnt_q; // rises since the word began
	always_ff @(posedge clock)
	begin
		if (rst || cs_n)
			rise_cnt_q <= 5'h0;
		else if ($rose(sclk))
			rise_cnt_q <= rise_cnt_q + 5'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// the serial clock rests low whenever no device is selected
	AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
		else $error("sclk high while deselected");
	// a rising sclk needs a select that has been low for a full half period
	AST_SCLK_SELECTED: assert property ($rose(sclk) |-> !cs_n && !$past(cs_n, 4))
		else $error("sclk rose without settled select");
	// high phase is exactly four clocks, so frame_header_stream are read at a steady rate
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("sclk high phase not four clocks");
	// low phase lasts at least four clocks
	AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk[*4])
		else $error("sclk low phase too short");
	// command bits stay put while the device may sample them
	AST_SDI_HOLD: assert property (sclk |-> $stable(sdi))
		else $error("sdi moved while sclk high");
	// answer bits stay put while the host may sample them
	AST_SDO_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdo))
		else $error("sdo moved while sclk high");
	// a word closes on the last falling edge, then a gap of four clocks
	AST_WORD_END: assert property ($rose(cs_n) |-> $fell(sclk) ##0 cs_n[*4])
		else $error("select released badly");
	// only whole 32-bit words are framed
	AST_BIT_COUNT: assert property ($rose(cs_n) |-> rise_cnt_q == 5'h0)
		else $error("word not 32 bits");
	// the link leaves reset quiet
	AST_RESET_LEVELS: assert property ($fell(rst) |-> !sdo && !sclk && cs_n && !sdi)
		else $error("link not idle after reset");
endmodule : efs_link_properties

// ==== ecg_frame_stream_gang_setup_bench.sv ====
// self-checking bench: host end and device end joined over one link
`timescale 1ns/1ns
module ecg_frame_stream_gang_setup_bench;
	import efs_pkg::*;
	localparam int LIMIT = 60000; // run needs about a quarter of this
	logic        clock = 1'b0;        // system clock
	logic        rst = 1'b1;          // synchronous reset
	logic [71:0] chan_samples = '0;   // channel samples
	logic [23:0] resp_magnitude = '0; // respiration word
	logic [23:0] leadoff_status = '0; // lead-off word
	logic        pace_event = 1'b0;   // pace candidate
	logic [2:0]  pace_lead_hits = '0; // leads hit
	logic [23:0] pace_meas_in = '0;   // width and height
	logic        gang_sync_in = 1'b0; // sync from master
	logic        cmd_valid = 1'b0;    // command offered
	logic [31:0] cmd_word = '0;       // command word
	logic        stream_stop = 1'b0;  // leave streaming
	logic        gang_sync_out, cm_drive_out, cm_ext_select, clk_ext_select, converting;
	logic [23:0] pace_threshold, test_tone_cfg, filter_cfg; // register outputs
	logic        cmd_ready, rsp_valid, streaming;           // host handshake
	logic [31:0] rsp_word;        // received word
	int          fail_count = 0;  // mismatches
	int          checked = 0;     // comparisons
	int          cycles = 0;      // elapsed clocks
	int          regs [128];      // register model
	logic [31:0] seed = 32'h9c00; // random state
	logic [31:0] exp_ans;         // model answer to the last word
	bit          ans_known = 0;   // answer predictable
	logic [31:0] exp_fr [$];      // expected words after a header
	logic [23:0] s [3];           // samples held for the run

	efs_link_if link ();
	efs_device #(.FRAME_CYCLES(300)) i_efs_device (.clock(clock), .rst(rst), .link(link),
		.chan_samples(chan_samples), .resp_magnitude(resp_magnitude),
		.leadoff_status(leadoff_status), .pace_event(pace_event),
		.pace_lead_hits(pace_lead_hits), .pace_meas_in(pace_meas_in),
		.gang_sync_in(gang_sync_in), .gang_sync_out(gang_sync_out),
		.cm_drive_out(cm_drive_out), .cm_ext_select(cm_ext_select),
		.clk_ext_select(clk_ext_select), .converting(converting),
		.pace_threshold(pace_threshold), .test_tone_cfg(test_tone_cfg), .filter_cfg(filter_cfg));
	efs_host i_efs_host (.clock(clock), .rst(rst), .link(link), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word), .cmd_ready(cmd_ready), .stream_stop(stream_stop),
		.rsp_valid(rsp_valid), .rsp_word(rsp_word), .streaming(streaming));
	efs_link_properties i_efs_link_properties (.clock(clock), .rst(rst), .sclk(link.sclk),
		.cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo));

	////////////////////////////////////////////////////////////////////////////
	// clock and hang guard; a stalled handshake ends the run as a failure
	always #50 clock = ~clock;
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			fail_count++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [23:0] rnd();
		seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
		return seed[23:0];
	endfunction : rnd

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one received word, bounded so a silent link cannot hang here
	task automatic get_word(output logic [31:0] w);
		int n;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 400);
		chk("word arrived", 32'h1, 32'(rsp_valid));
		w = rsp_word;
	endtask : get_word

	// one command; its answer belongs to the previous word, so the model lags one
	task automatic send(input logic [31:0] w);
		logic [31:0] r;
		cmd_valid <= 1'b1;
		cmd_word  <= w;
		do
			@(posedge clock);
		while (cmd_ready !== 1'b1 && cycles < LIMIT);
		cmd_valid <= 1'b0;
		get_word(r);
		if (ans_known)
			chk("answer", exp_ans, r);
		exp_ans = w[31] ? 32'h0 : {1'b0, w[30:24], 24'(regs[w[30:24]])};
		if (w[31] && w[30:24] inside {7'h01, 7'h04, 7'h05, 7'h08, 7'h0a, 7'h0b})
			regs[w[30:24]] = w[23:0];
		ans_known = 1;
	endtask : send

	// leave the stream at a word end; the next answer is a stream word
	task automatic stop_stream();
		stream_stop <= 1'b1;
		do
			@(posedge clock);
		while (streaming !== 1'b0 && cycles < LIMIT);
		stream_stop <= 1'b0;
		repeat (CS_GAP_CYC) @(posedge clock);
		ans_known = 0;
	endtask : stop_stream

	// find a header, check its pace flags, optionally fire a pace, check the frame
	task automatic frame_chk(input logic [2:0] flags, input logic [23:0] meas, input bit pulse);
		logic [31:0] w;
		int n;
		n = 0;
		do
		begin
			get_word(w);
			n++;
		end
		while (w[31:24] !== 8'h40 && n < 9);
		chk("header tag", 32'h40, {24'h0, w[31:24]});
		chk("header flags", {29'h0, flags}, {29'h0, w[22:20]});
		if (pulse)
		begin
			pace_meas_in   <= meas;
			pace_lead_hits <= 3'b101;
			pace_event     <= 1'b1;
			@(posedge clock);
			pace_event <= 1'b0;
		end
		foreach (exp_fr[i])
		begin
			get_word(w);
			chk("frame word", exp_fr[i], w);
		end
	endtask : frame_chk

	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		regs[7] = PACE_THR_RST;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		foreach (s[i])
			s[i] = rnd();
		chan_samples   <= {s[2], s[1], s[0]};
		resp_magnitude <= rnd();
		leadoff_status <= rnd();
		// reset values, write and read back, an unmapped place
		foreach (regs[i])
			if (i inside {7, 1, 4, 11})
				send({1'b0, 7'(i), 24'h0});
		send(32'h84000f8f);
		send(32'h8b000008);
		send({1'b1, A_TEST_CTL, rnd()});
		send(32'hff123456);
		foreach (regs[i])
			if (i inside {4, 11, 8, 127})
				send({1'b0, 7'(i), 24'h0});
		chk("threshold", {8'h0, PACE_THR_RST}, {8'h0, pace_threshold});
		chk("filter", 32'h8, {8'h0, filter_cfg});
		chk("tone", 32'(regs[8]), {8'h0, test_tone_cfg});
		$display("test registers done");
		// gang master: seven words in vector form, pace accepted and refused
		send(32'h8a1f9600);
		send(32'h85e0000b);
		chk("cm drive", 32'h1, 32'(cm_drive_out));
		send(32'h81e004be);
		chk("converting", 32'h1, 32'(converting));
		chk("sync out", 32'h1, 32'(gang_sync_out));
		exp_fr = '{{8'h11, 24'(s[1] - s[0])}, {8'h12, 24'(s[2] - s[1])},
			{8'h13, 24'(s[0] - s[2])}, {8'h1a, 24'h000a05}, {8'h1b, resp_magnitude},
			{8'h1c, leadoff_status}};
		send(32'h40000000);
		frame_chk(3'b000, 24'h000a05, 1);
		frame_chk(3'b101, 24'h000a00, 1);
		frame_chk(3'b000, 24'h000a00, 0);
		stop_stream();
		$display("test master stream done");
		// a command in mid-stream halts conversion; then set up as gang slave
		send(32'h8a1ff610);
		chk("halted", 32'h0, 32'(converting));
		chk("sync dropped", 32'h0, 32'(gang_sync_out));
		send(32'h85000004);
		chk("cm select", 32'h1, 32'(cm_ext_select));
		send(32'h81e000de);
		chk("ext clock", 32'h1, 32'(clk_ext_select));
		repeat (20) @(posedge clock);
		chk("held off", 32'h0, 32'(converting));
		gang_sync_in <= 1'b1;
		repeat (6) @(posedge clock);
		chk("started", 32'h1, 32'(converting));
		$display("test slave start done");
		// slave stream: five words, electrode form
		exp_fr = '{{8'h11, s[0]}, {8'h12, s[1]}, {8'h13, s[2]}, {8'h1c, leadoff_status}};
		send(32'h40000000);
		frame_chk(3'b000, 24'h0, 0);
		frame_chk(3'b000, 24'h0, 0);
		stop_stream();
		send(32'h0a000000);
		send(32'h01000000);
		$display("test slave stream done");
		summarize();
	end
endmodule : ecg_frame_stream_gang_setup_bench
